// ===== common/mctr_pkg.sv
// Types for the microcycle timing and result path block
package mctr_pkg;
  typedef enum logic [1:0] {
    MCTR_SEL_RDBUS   = 2'b00,
    MCTR_SEL_RESULT  = 2'b01,
    MCTR_SEL_SHIFTED = 2'b10,
    MCTR_SEL_BUSDATA = 2'b11
  } mctr_sel_e;
  typedef enum logic [1:0] {
    MCTR_LEN_SHORT = 2'b00,
    MCTR_LEN_MID   = 2'b01,
    MCTR_LEN_LONG  = 2'b10,
    MCTR_LEN_LONG2 = 2'b11
  } mctr_len_e;
  typedef struct packed {
    logic      clock_halt_bit;
    mctr_len_e cycle_length_sel;
    logic      instr_reg_load_en;
    logic      bus_addr_load_en;
    logic      operand_reg_load_en;
    logic      result_reg_load_en;
    logic      upper_byte_write_en;
    logic      lower_byte_write_en;
    mctr_sel_e result_select_mux;
  } mctr_uword_s;
  typedef struct packed {
    logic first;
    logic second;
    logic third;
  } mctr_phase_s;
endpackage

// ===== common/mctr_regs.svh
// Constants for the microcycle timing and result path block
// Functional notes
// - Equality when nine low pointer bits match nine low switch bits.
// - Maintenance stop halts microcycles as soon as equality asserts.
// - Equality is driven out as a scope sync output.
// - Run and idle flip-flops decide whether pulse generation starts.
// - Clock-halt bit stops further microcycles until restart or continue.
// - Two microword bits select one of three microcycle lengths.
// - Each microcycle not cut short by a maintenance stop yields first, second and third timing pulses.
// - Recycle pulse at cycle end starts next microcycle while running.
// - Load pulses reach each register only with its microword enable.
// - Upper and lower byte write strobes gated by separate bits.
// - Two-bit select picks read bus, result, shifted result, bus data.
// - Sixteen-bit mux output feeds all downstream consumers.
// - Sixteen-bit result register captures ALU output on its load pulse.
// - Result register feeds mux and drives bus data when sending.
// - Operand register loads from the mux output.
`ifndef MCTR_REGS_SVH
`define MCTR_REGS_SVH
`define MCTR_DW        16
`define MCTR_PW        9
`define MCTR_CW        4
// Phase positions, counted from microcycle start, per length
`define MCTR_P1_AT     4'h0
`define MCTR_P2_AT     4'h1
`define MCTR_P3_SHORT  4'h2
`define MCTR_P3_MID    4'h4
`define MCTR_P3_LONG   4'h6
`define MCTR_END_SHORT 4'h3
`define MCTR_END_MID   4'h5
`define MCTR_END_LONG  4'h7
`define MCTR_CNT_ZERO  4'h0
`define MCTR_CNT_ONE   4'h1
`define MCTR_DATA_ZERO 16'h0000
`endif

// ===== core/mctr_core.sv
// Microcycle timing, load gating and result path
`timescale 1ns/10ps
`default_nettype none
`include "mctr_regs.svh"
module mctr_core (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire mctr_pkg::mctr_uword_s   uword,
  input  wire logic [8:0]              buffered_microprogram_pointer,
  input  wire logic [8:0]              switch_register,
  input  wire logic                    maint_stop_sel,
  input  wire logic                    restart_req,
  input  wire logic                    continue_req,
  input  wire logic                    shift_left,
  input  wire logic                    shift_fill,
  input  wire logic [15:0]             reg_read_bus,
  input  wire logic [15:0]             alu_out,
  input  wire logic [15:0]             bus_data_in,
  input  wire logic                    bus_send,
  output logic                         pointer_match,
  output logic                         running,
  output mctr_pkg::mctr_phase_s        phase,
  output logic                         recycle_pulse,
  output logic                         instr_reg_load,
  output logic                         bus_addr_load,
  output logic                         upper_byte_write,
  output logic                         lower_byte_write,
  output logic [15:0]                  result_mux_out,
  output logic [15:0]                  operand_reg,
  output logic [15:0]                  result_reg,
  output logic [15:0]                  bus_data_out,
  output logic                         bus_data_oe
);
  import mctr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Run / idle control and phase counter
  logic                   run_r, run_nxt;
  logic                   idle_r, idle_nxt;
  logic [`MCTR_CW-1:0]    cnt_r, cnt_nxt;
  logic                   match_now;
  logic [`MCTR_CW-1:0]    p3_at, end_at;
  logic                   p1_now, p2_now, p3_now, end_now;

  assign match_now = (buffered_microprogram_pointer ==
                      switch_register);

  always_comb begin
    unique case (uword.cycle_length_sel)
      MCTR_LEN_SHORT: begin
        p3_at  = `MCTR_P3_SHORT;
        end_at = `MCTR_END_SHORT;
      end
      MCTR_LEN_MID: begin
        p3_at  = `MCTR_P3_MID;
        end_at = `MCTR_END_MID;
      end
      MCTR_LEN_LONG, MCTR_LEN_LONG2: begin
        p3_at  = `MCTR_P3_LONG;
        end_at = `MCTR_END_LONG;
      end
    endcase
  end

  assign p1_now  = run_r && (cnt_r == `MCTR_P1_AT);
  assign p2_now  = run_r && (cnt_r == `MCTR_P2_AT);
  assign p3_now  = run_r && (cnt_r == p3_at);
  assign end_now = run_r && (cnt_r == end_at);

  // Halt bit stops at cycle end; a maintenance stop on equality ends the cycle at once
  always_comb begin
    run_nxt  = run_r;
    idle_nxt = idle_r;
    cnt_nxt  = cnt_r;
    if (run_r) begin
      if (end_now) begin
        cnt_nxt = `MCTR_CNT_ZERO;
        if (uword.clock_halt_bit) begin
          run_nxt  = 1'b0;
          idle_nxt = 1'b1;
        end
      end else begin
        cnt_nxt = cnt_r + `MCTR_CNT_ONE;
      end
      if (maint_stop_sel && match_now) begin
        run_nxt  = 1'b0;
        idle_nxt = 1'b1;
        cnt_nxt  = `MCTR_CNT_ZERO;
      end
    end else if (restart_req || continue_req) begin
      run_nxt  = 1'b1;
      idle_nxt = 1'b0;
      cnt_nxt  = `MCTR_CNT_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_r  <= 1'b0;
      idle_r <= 1'b1;
      cnt_r  <= `MCTR_CNT_ZERO;
    end else begin
      run_r  <= run_nxt;
      idle_r <= idle_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result path
  logic [15:0] shifted;
  logic [15:0] mux_now;
  logic [15:0] result_nxt, operand_nxt;

  assign shifted = shift_left ? {result_reg[14:0], shift_fill}
                              : {shift_fill, result_reg[15:1]};

  always_comb begin
    unique case (uword.result_select_mux)
      MCTR_SEL_RDBUS:   mux_now = reg_read_bus;
      MCTR_SEL_RESULT:  mux_now = result_reg;
      MCTR_SEL_SHIFTED: mux_now = shifted;
      MCTR_SEL_BUSDATA: mux_now = bus_data_in;
    endcase
  end

  // Loads happen on the third pulse so operands settle first
  always_comb begin
    result_nxt  = result_reg;
    operand_nxt = operand_reg;
    if (p3_now && uword.result_reg_load_en)
      result_nxt = alu_out;
    if (p3_now && uword.operand_reg_load_en)
      operand_nxt = mux_now;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pointer_match    <= 1'b0;
      running          <= 1'b0;
      phase            <= '0;
      recycle_pulse    <= 1'b0;
      instr_reg_load   <= 1'b0;
      bus_addr_load    <= 1'b0;
      upper_byte_write <= 1'b0;
      lower_byte_write <= 1'b0;
      result_mux_out   <= `MCTR_DATA_ZERO;
      operand_reg      <= `MCTR_DATA_ZERO;
      result_reg       <= `MCTR_DATA_ZERO;
      bus_data_out     <= `MCTR_DATA_ZERO;
      bus_data_oe      <= 1'b0;
    end else begin
      pointer_match    <= match_now;
      running          <= run_r;
      phase.first      <= p1_now;
      phase.second     <= p2_now;
      phase.third      <= p3_now;
      recycle_pulse    <= end_now && !uword.clock_halt_bit &&
                          !(maint_stop_sel && match_now);
      instr_reg_load   <= p3_now && uword.instr_reg_load_en;
      bus_addr_load    <= p3_now && uword.bus_addr_load_en;
      upper_byte_write <= p3_now && uword.upper_byte_write_en;
      lower_byte_write <= p3_now && uword.lower_byte_write_en;
      result_mux_out   <= mux_now;
      operand_reg      <= operand_nxt;
      result_reg       <= result_nxt;
      bus_data_out     <= result_nxt;
      bus_data_oe      <= bus_send;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Registered outputs lag one edge, so many checks compare with $past
  chk_match_out: assert property (
    @(posedge clk) disable iff (sys_rst)
    (buffered_microprogram_pointer == switch_register) |=> pointer_match)
    else $error("pointer match not reported");
  chk_no_match: assert property (
    @(posedge clk) disable iff (sys_rst)
    (buffered_microprogram_pointer != switch_register) |=> !pointer_match)
    else $error("false pointer match");
  chk_maint_stop: assert property (
    @(posedge clk) disable iff (sys_rst)
    (run_r && maint_stop_sel && match_now) |=> !run_r)
    else $error("maintenance stop did not halt");
  chk_maint_count: assert property (
    @(posedge clk) disable iff (sys_rst)
    (run_r && maint_stop_sel && match_now) |=> (cnt_r == `MCTR_CNT_ZERO))
    else $error("maintenance stop left counter running");
  // First edge after reset is skipped so no reset-time sample is compared
  chk_sync_out: assert property (
    @(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> (pointer_match == $past(match_now)))
    else $error("sync output mismatch");
  chk_keep_run: assert property (
    @(posedge clk) disable iff (sys_rst)
    (run_r && !maint_stop_sel && !end_now) |=> run_r)
    else $error("run dropped without stop cause");
  chk_idle_start: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!run_r && !restart_req && !continue_req) |=> !run_r)
    else $error("started without request");
  chk_start_req: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!run_r && restart_req) |=> (run_r && cnt_r == `MCTR_CNT_ZERO))
    else $error("restart did not start cycle");
  chk_running_copy: assert property (
    @(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> (running == $past(run_r)))
    else $error("running output mismatch");
  chk_idle_quiet: assert property (
    @(posedge clk) disable iff (sys_rst)
    !run_r |=> !phase.first)
    else $error("pulse while idle");
  chk_halt_bit: assert property (
    @(posedge clk) disable iff (sys_rst)
    (end_now && uword.clock_halt_bit) |=> (idle_r && !run_r))
    else $error("halt bit ignored");
  chk_cont_req: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!run_r && continue_req) |=> run_r)
    else $error("continue did not resume");
  chk_short_len: assert property (
    @(posedge clk) disable iff (sys_rst)
    (p1_now && uword.cycle_length_sel == MCTR_LEN_SHORT) |->
      ##3 (cnt_r == `MCTR_END_SHORT || !run_r))
    else $error("short cycle length wrong");
  chk_mid_len: assert property (
    @(posedge clk) disable iff (sys_rst)
    (p1_now && uword.cycle_length_sel == MCTR_LEN_MID) |->
      ##5 (cnt_r == `MCTR_END_MID || !run_r))
    else $error("mid cycle length wrong");
  chk_long_len: assert property (
    @(posedge clk) disable iff (sys_rst)
    (p1_now && uword.cycle_length_sel[1]) |->
      ##7 (cnt_r == `MCTR_END_LONG || !run_r))
    else $error("long cycle length wrong");
  chk_phase_order: assert property (
    @(posedge clk) disable iff (sys_rst)
    (p1_now && !(maint_stop_sel && match_now)) |=> p2_now)
    else $error("second pulse missing");
  chk_third_gap: assert property (
    @(posedge clk) disable iff (sys_rst)
    (p2_now && uword.cycle_length_sel == MCTR_LEN_SHORT) |=>
      (p3_now || !run_r))
    else $error("third pulse missing");
  chk_first_out: assert property (
    @(posedge clk) disable iff (sys_rst)
    p1_now |=> phase.first)
    else $error("first pulse not output");
  chk_recycle: assert property (
    @(posedge clk) disable iff (sys_rst)
    recycle_pulse |-> (run_r && cnt_r == `MCTR_P1_AT))
    else $error("recycle did not restart cycle");
  chk_recycle_end: assert property (
    @(posedge clk) disable iff (sys_rst)
    (end_now && !uword.clock_halt_bit && !(maint_stop_sel && match_now))
      |=> recycle_pulse)
    else $error("recycle missing at cycle end");
  chk_recycle_halt: assert property (
    @(posedge clk) disable iff (sys_rst)
    (end_now && uword.clock_halt_bit) |=> !recycle_pulse)
    else $error("recycle despite halt");
  chk_ir_gate: assert property (
    @(posedge clk) disable iff (sys_rst)
    instr_reg_load |-> $past(p3_now && uword.instr_reg_load_en))
    else $error("ungated instruction load");
  chk_ba_gate: assert property (
    @(posedge clk) disable iff (sys_rst)
    bus_addr_load |-> $past(p3_now && uword.bus_addr_load_en))
    else $error("ungated address load");
  chk_byte_wr: assert property (
    @(posedge clk) disable iff (sys_rst)
    upper_byte_write |-> $past(uword.upper_byte_write_en))
    else $error("ungated upper write");
  chk_lower_wr: assert property (
    @(posedge clk) disable iff (sys_rst)
    lower_byte_write |-> $past(p3_now && uword.lower_byte_write_en))
    else $error("ungated lower write");
  chk_upper_on: assert property (
    @(posedge clk) disable iff (sys_rst)
    (p3_now && uword.upper_byte_write_en) |=> upper_byte_write)
    else $error("upper write missing");
  chk_mux_rdbus: assert property (
    @(posedge clk) disable iff (sys_rst)
    (uword.result_select_mux == MCTR_SEL_RDBUS) |=>
      (result_mux_out == $past(reg_read_bus)))
    else $error("read bus not selected");
  chk_mux_out: assert property (
    @(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> (result_mux_out == $past(mux_now)))
    else $error("mux output not registered");
  chk_result_load: assert property (
    @(posedge clk) disable iff (sys_rst)
    (p3_now && uword.result_reg_load_en) |=> (result_reg == $past(alu_out)))
    else $error("result register not loaded");
  chk_result_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    !(p3_now && uword.result_reg_load_en) |=> $stable(result_reg))
    else $error("result register changed without load");
  chk_mux_result: assert property (
    @(posedge clk) disable iff (sys_rst)
    (uword.result_select_mux == MCTR_SEL_RESULT) |=>
      (result_mux_out == $past(result_reg)))
    else $error("result feedback not selected");
  chk_bus_out: assert property (
    @(posedge clk) disable iff (sys_rst)
    bus_data_out == result_reg)
    else $error("bus data differs from result");
  chk_bus_oe: assert property (
    @(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> (bus_data_oe == $past(bus_send)))
    else $error("bus enable mismatch");
  chk_operand_load: assert property (
    @(posedge clk) disable iff (sys_rst)
    (p3_now && uword.operand_reg_load_en) |=> (operand_reg == $past(mux_now)))
    else $error("operand register not loaded");
  chk_mux_busdata: assert property (
    @(posedge clk) disable iff (sys_rst)
    (uword.result_select_mux == MCTR_SEL_BUSDATA) |=>
      (result_mux_out == $past(bus_data_in)))
    else $error("bus data not selected");
  chk_shift_left: assert property (
    @(posedge clk) disable iff (sys_rst)
    (uword.result_select_mux == MCTR_SEL_SHIFTED && shift_left) |=>
      (result_mux_out == $past({result_reg[14:0], shift_fill})))
    else $error("left shift wrong");
  chk_shift_right: assert property (
    @(posedge clk) disable iff (sys_rst)
    (uword.result_select_mux == MCTR_SEL_SHIFTED && !shift_left) |=>
      (result_mux_out == $past({shift_fill, result_reg[15:1]})))
    else $error("right shift wrong");
endmodule
`default_nettype wire

// ===== sim/mctr_partner.sv
// Control store and datapath model on the far side of the block
`timescale 1ns/10ps
`default_nettype none
module mctr_partner (
  input  wire logic                  clk,
  input  wire mctr_pkg::mctr_uword_s uw_in,
  input  wire logic [15:0]           d_in,
  output mctr_pkg::mctr_uword_s      uword,
  output logic [15:0]                alu_out,
  output logic [15:0]                rd_bus,
  output logic [15:0]                bus_in
);
  import mctr_pkg::*;
  // Store read is prompt; datapath values lag one clock
  assign uword = uw_in;
  always_ff @(posedge clk) begin
    alu_out <= d_in;
    rd_bus <= ~d_in;
    bus_in <= {d_in[7:0], d_in[15:8]};
  end
endmodule
`default_nettype wire

// ===== sim/test_microcycle_timing_and_result_path.sv
// Self-checking bench for the microcycle timing and result path
`timescale 1ns/10ps
`default_nettype none
`include "mctr_regs.svh"
module test_microcycle_timing_and_result_path;
  import mctr_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, maint = 1'b0, rst_req = 1'b0;
  logic cont_req = 1'b0, sl = 1'b0, sf = 1'b0, bsend = 1'b0;
  logic [8:0] bp = 9'h000, sw = 9'h000, p;
  logic [15:0] d = 16'h0000, exp_r = 16'h0000;
  logic [15:0] alu, rdb, bin, mux_o, op_r, res_r, bd_o;
  logic match, running, recyc, ir_ld, ba_ld, ub_wr, lb_wr, bd_oe;
  mctr_uword_s uw = '0, u, pu;
  mctr_phase_s phase;
  int mismatches = 0, comparisons = 0, tf0, tf1, ts, tt, nf;
  int n[5];
  always #25 clk = ~clk;
  mctr_partner store (.clk(clk), .uw_in(uw), .d_in(d), .uword(pu),
    .alu_out(alu), .rd_bus(rdb), .bus_in(bin));
  mctr_core dut (.clk(clk), .sys_rst(sys_rst), .uword(pu),
    .buffered_microprogram_pointer(bp), .switch_register(sw),
    .maint_stop_sel(maint), .restart_req(rst_req), .continue_req(cont_req),
    .shift_left(sl), .shift_fill(sf), .reg_read_bus(rdb), .alu_out(alu),
    .bus_data_in(bin), .bus_send(bsend), .pointer_match(match),
    .running(running), .phase(phase), .recycle_pulse(recyc),
    .instr_reg_load(ir_ld), .bus_addr_load(ba_ld),
    .upper_byte_write(ub_wr), .lower_byte_write(lb_wr),
    .result_mux_out(mux_o), .operand_reg(op_r), .result_reg(res_r),
    .bus_data_out(bd_o), .bus_data_oe(bd_oe));
  ////////////////////////////////////////////////////////////////////////
  function automatic int end_at(mctr_len_e s);
    return s == MCTR_LEN_SHORT ? `MCTR_END_SHORT + 1 :
      s == MCTR_LEN_MID ? `MCTR_END_MID + 1 : `MCTR_END_LONG + 1;
  endfunction
  function automatic int p3_at(mctr_len_e s);
    return s == MCTR_LEN_SHORT ? `MCTR_P3_SHORT :
      s == MCTR_LEN_MID ? `MCTR_P3_MID : `MCTR_P3_LONG;
  endfunction
  function automatic logic [15:0] mux_exp(mctr_sel_e s, logic l, f);
    case (s)
      MCTR_SEL_RDBUS:   return ~d;
      MCTR_SEL_RESULT:  return exp_r;
      MCTR_SEL_SHIFTED: return l ? {exp_r[14:0], f} : {f, exp_r[15:1]};
      default:          return {d[7:0], d[15:8]};
    endcase
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Two microcycles back to back, halt bit raised during the second
  task automatic run(input mctr_uword_s w, input logic by_cont);
    nf = 0;
    n = '{default: 0};
    uw <= w;
    repeat (3) @(posedge clk);
    if (by_cont) cont_req <= 1'b1;
    else rst_req <= 1'b1;
    @(posedge clk);
    cont_req <= 1'b0;
    rst_req <= 1'b0;
    for (int c = 0; c < 40; c++) begin
      @(posedge clk);
      if (nf == 2 && !w.clock_halt_bit) begin
        w.clock_halt_bit = 1'b1;
        uw <= w;
      end
      #1;
      n[0] += ir_ld;
      n[1] += ba_ld;
      n[2] += ub_wr;
      n[3] += lb_wr;
      n[4] += recyc;
      if (phase.second && nf == 1) ts = c;
      if (phase.third && nf == 1) tt = c;
      if (phase.first && nf == 0) tf0 = c;
      if (phase.first && nf == 1) tf1 = c;
      if (phase.first) nf++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h08f76a69));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      u = mctr_uword_s'(12'($urandom));
      u.clock_halt_bit = 1'b0;
      u.cycle_length_sel = mctr_len_e'(i % 4);
      u.result_select_mux = i[1] ? MCTR_SEL_BUSDATA : MCTR_SEL_RDBUS;
      p = 9'($urandom);
      bp <= p;
      sw <= i[0] ? p : p ^ (9'h001 << (i % 9));
      d <= 16'($urandom);
      bsend <= i[0];
      run(u, i[2]);
      chk("span", 16'(end_at(u.cycle_length_sel)), 16'(tf1 - tf0));
      chk("second", 16'(`MCTR_P2_AT), 16'(ts - tf0));
      chk("third", 16'(p3_at(u.cycle_length_sel)), 16'(tt - tf0));
      chk("recycle", 16'h0001, 16'(n[4]));
      chk("cycles", 16'h0002, 16'(nf));
      chk("running", 16'h0000, {15'h0000, running});
      chk("ir_ld", 16'(2 * u.instr_reg_load_en), 16'(n[0]));
      chk("ba_ld", 16'(2 * u.bus_addr_load_en), 16'(n[1]));
      chk("ub_wr", 16'(2 * u.upper_byte_write_en), 16'(n[2]));
      chk("lb_wr", 16'(2 * u.lower_byte_write_en), 16'(n[3]));
      chk("match", {15'h0000, i[0]}, {15'h0000, match});
      if (u.result_reg_load_en) exp_r = d;
      chk("result", exp_r, res_r);
      if (u.operand_reg_load_en)
        chk("operand", mux_exp(u.result_select_mux, 1'b0, 1'b0), op_r);
      chk("bus_out", exp_r, bd_o);
      chk("bus_oe", {15'h0000, i[0]}, {15'h0000, bd_oe});
      for (int s = 0; s < 4; s++) begin
        @(posedge clk);
        u.result_select_mux = mctr_sel_e'(s);
        uw <= u;
        sl <= 1'($urandom);
        sf <= 1'($urandom);
        repeat (3) @(posedge clk);
        #1;
        chk("mux", mux_exp(u.result_select_mux, sl, sf), mux_o);
      end
      $display("test %0d done", i);
    end
    // Equal pointer with stop selected must not keep cycling
    @(posedge clk);
    maint <= 1'b1;
    sw <= bp;
    u.clock_halt_bit = 1'b0;
    uw <= u;
    repeat (3) @(posedge clk);
    rst_req <= 1'b1;
    @(posedge clk);
    rst_req <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    chk("stop", 16'h0000, {15'h0000, running});
    $display("test stop done");
    end_sim();
  end
endmodule
`default_nettype wire
